// ---- dither_and_stamp_control.v ----
// dither, sample stamp and serial link enable register bank behind classic Wishbone
//
// How it works
// - dither control reset value comes from the fuse word, captured after reset.
// - dither_on bit 0 turns internal dither on for the converter cores.
// - bit 1 picks dither size: 0 small for noise, 1 large for spurs.
// - bit 2 steers rounding error: 0 into noise, 1 into offset and spurs.
// - stamp_insertion_on puts the external stamp in each output sample lsb.
// - stamp path latency is four cycles longer than the converter sample latency, from the pin synchroniser and filter.
// - stamp bit takes lowest link field bit; converter lsb kept when field wider.
// - control bits per sample reported as zero in lane alignment data.
// - link enable register sits at 0x200 and resets to 0x01.
// - link enable clear holds link in reset, serializers off.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "dither_stamp_regs.vh"
module dither_and_stamp_control (
  input  wire                     clk_i,
  input  wire                     rst_i,
  // classic wishbone slave
  input  wire                     cyc_i,
  input  wire                     stb_i,
  input  wire                     we_i,
  input  wire [11:0]              adr_i,
  input  wire [3:0]               sel_i,
  input  wire [31:0]              dat_i,
  output wire [31:0]              dat_o,
  output wire                     ack_o,
  output wire                     err_o,
  // fuse word for the dither control reset value
  input  wire [7:0]               fuse_dither_i,
  // converter sample path and stamp pin
  input  wire [`CONV_WIDTH-1:0]   conv_sample_i,
  input  wire                     conv_valid_i,
  input  wire                     stamp_pin_i,
  output wire [`LINK_WIDTH-1:0]   link_sample_o,
  output wire                     link_valid_o,
  // core controls
  output wire                     dither_on_o,
  output wire                     dither_size_select_o,
  output wire                     rounding_error_target_o,
  output wire                     link_reset_o,
  output wire                     serializer_power_down_o,
  output wire                     serializer_clock_gate_o,
  output wire [7:0]               lane_align_cs_o
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  function [2:0] decode;
    input [9:0] idx;
    begin
      case (idx)
        `IDX_DITHER_CONTROL: decode = 3'h1;
        `IDX_STAMP_CONTROL:  decode = 3'h2;
        `IDX_LINK_ENABLE:    decode = 3'h3;
        `IDX_LINK_STATUS:    decode = 3'h4;
        default:             decode = 3'h0;
      endcase
    end
  endfunction

  localparam [2:0] SEL_NONE   = 3'h0;
  localparam [2:0] SEL_DITHER = 3'h1;
  localparam [2:0] SEL_STAMP  = 3'h2;
  localparam [2:0] SEL_LINK   = 3'h3;
  localparam [2:0] SEL_STATUS = 3'h4;

  localparam [1:0] ST_RESET   = 2'h0;
  localparam [1:0] ST_FUSE    = 2'h1;
  localparam [1:0] ST_RUN     = 2'h2;

  reg  [1:0]                      state_q;
  reg  [7:0]                      dither_q;
  reg  [7:0]                      stamp_ctl_q;
  reg  [7:0]                      link_en_q;
  reg                             ack_q;
  reg                             err_q;
  reg  [31:0]                     rdata_q;
  reg  [2:0]                      stamp_sync_q;
  reg                             stamp_filt_q;
  reg  [`LINK_WIDTH-1:0]          link_sample_q;
  reg                             link_valid_q;

  wire [2:0]                      reg_sel;
  wire                            req;
  wire                            wr_lane0;
  reg  [7:0]                      rd_byte;

  assign reg_sel  = decode(adr_i[11:2]);
  assign req      = cyc_i & stb_i & ~ack_q & ~err_q;
  assign wr_lane0 = req & we_i & sel_i[0] & (state_q == ST_RUN);

  // ****************************************************************
  // reset sequencing and registers
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_RESET;
    end else begin
      case (state_q)
        ST_RESET: state_q <= ST_FUSE;
        ST_FUSE:  state_q <= ST_RUN;
        ST_RUN:   state_q <= ST_RUN;
        default:  state_q <= ST_RESET;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dither_q    <= 8'h00;
      stamp_ctl_q <= `RST_STAMP_CONTROL;
      link_en_q   <= `RST_LINK_ENABLE;
    end else if (state_q == ST_FUSE) begin
      dither_q    <= fuse_dither_i;
    end else if (wr_lane0) begin
      if (reg_sel == SEL_DITHER) begin
        dither_q <= dat_i[7:0];
      end
      if (reg_sel == SEL_STAMP) begin
        stamp_ctl_q <= dat_i[7:0];
      end
      // link registers changed by software order
      if (reg_sel == SEL_LINK) begin
        link_en_q <= dat_i[7:0];
      end
    end
  end

  // ****************************************************************
  // bus answer
  // ****************************************************************
  always @* begin
    case (reg_sel)
      SEL_DITHER: rd_byte = dither_q;
      SEL_STAMP:  rd_byte = stamp_ctl_q;
      SEL_LINK:   rd_byte = link_en_q;
      SEL_STATUS: rd_byte = {5'h00, (state_q == ST_RUN), link_reset_o, stamp_filt_q};
      default:    rd_byte = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= req & (reg_sel != SEL_NONE) & (state_q == ST_RUN);
      err_q   <= req & ((reg_sel == SEL_NONE) | (state_q != ST_RUN));
      rdata_q <= (req & ~we_i) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  assign ack_o = ack_q;
  assign err_o = err_q;
  assign dat_o = rdata_q;

  // ****************************************************************
  // core controls
  // ****************************************************************
  // dither on
  assign dither_on_o             = dither_q[`FLD_DITHER_ON];
  assign dither_size_select_o    = dither_q[`FLD_DITHER_SIZE];
  assign rounding_error_target_o = dither_q[`FLD_ROUND_TARGET];
  assign link_reset_o            = ~link_en_q[`FLD_SERIAL_LINK_ON];
  assign serializer_power_down_o = ~link_en_q[`FLD_SERIAL_LINK_ON];
  assign serializer_clock_gate_o = ~link_en_q[`FLD_SERIAL_LINK_ON];
  assign lane_align_cs_o         = 8'h00;

  // ****************************************************************
  // stamp pin synchroniser
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      stamp_sync_q <= 3'h0;
      stamp_filt_q <= 1'b0;
    end else begin
      stamp_sync_q <= {stamp_sync_q[1:0], stamp_pin_i};
      if (stamp_sync_q[1] == stamp_sync_q[2]) begin
        stamp_filt_q <= stamp_sync_q[2];
      end
    end
  end

  // ****************************************************************
  // sample path with stamp insertion
  // ****************************************************************
  wire                            stamp_dly;
  wire [`CONV_WIDTH-1:0]          sample_dly;
  wire                            valid_dly;

  stamp_delay_line u_delay (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .stamp_i  (stamp_filt_q),
    .sample_i (conv_sample_i),
    .valid_i  (conv_valid_i),
    .stamp_o  (stamp_dly),
    .sample_o (sample_dly),
    .valid_o  (valid_dly)
  );

  always @(posedge clk_i) begin
    if (rst_i | link_reset_o) begin
      link_sample_q <= {`LINK_WIDTH{1'b0}};
      link_valid_q  <= 1'b0;
    end else begin
      link_valid_q  <= valid_dly;
      link_sample_q <= {sample_dly, {(`LINK_WIDTH-`CONV_WIDTH){1'b0}}};
      if (stamp_ctl_q[`FLD_STAMP_INSERTION]) begin
        // lowest field bit, converter lsb kept
        link_sample_q[0] <= stamp_dly;
      end
    end
  end

  assign link_sample_o = link_sample_q;
  assign link_valid_o  = link_valid_q;
endmodule // dither_and_stamp_control

// ---- dither_and_stamp_control_bench.sv ----
// self-checking bench for the dither and stamp control bank
`timescale 1ns/10ps
`include "dither_stamp_regs.vh"
module dither_and_stamp_control_bench;
  reg clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, conv_valid_i = 1'b0, stamp_pin_i = 1'b1;
  reg [11:0] adr_i = 12'h000, conv_sample_i = 12'h000;
  reg [3:0] sel_i = 4'h0;
  reg [31:0] dat_i = 32'h0, rnd = 32'h1537;
  reg [7:0] fuse_dither_i = 8'h00, fuse, m;
  reg [9:0] ix;
  wire [31:0] dat_o;
  wire ack_o, err_o, link_valid_o, link_reset_o, serializer_clock_gate_o;
  wire [15:0] link_sample_o;
  integer failures = 0, comparisons = 0, i;
  reg [32:0] rd_q[$];
  reg [15:0] smp_q[$];
  always #2.5 clk_i = ~clk_i;
  dither_and_stamp_control DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .fuse_dither_i(fuse_dither_i), .conv_sample_i(conv_sample_i), .conv_valid_i(conv_valid_i),
    .stamp_pin_i(stamp_pin_i), .link_sample_o(link_sample_o), .link_valid_o(link_valid_o),
    .dither_on_o(), .dither_size_select_o(), .rounding_error_target_o(), .link_reset_o(link_reset_o),
    .serializer_power_down_o(), .serializer_clock_gate_o(serializer_clock_gate_o), .lane_align_cs_o());
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input [32:0] got, input [32:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  // one classic cycle; the note is the expected {err, read data}
  task wb(input w, input [9:0] a, input [3:0] s, input [31:0] d, input [32:0] exp);
    integer n;
    begin
      rd_q.push_back(exp);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 2'b00, s, d};
      n = 0;
      do begin @(posedge clk_i); n = n + 1; end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
      if (n >= 50) failures = failures + 1;
      {cyc_i, stb_i, we_i} <= 3'b000;
    end
  endtask
  task stream(input st);
    begin
      repeat (12) begin
        @(posedge clk_i);
        rnd = lfsr(rnd);
        conv_valid_i <= rnd[13];
        conv_sample_i <= rnd[11:0];
        if (rnd[13]) smp_q.push_back({rnd[11:0], 3'b000, st});
      end
      @(posedge clk_i);
      conv_valid_i <= 1'b0;
      repeat (10) @(posedge clk_i);
    end
  endtask
  // ****************************************************************
  // result watchers
  // ****************************************************************
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 || err_o === 1'b1) check(err_o ? {1'b1, 32'h0} : {1'b0, dat_o}, rd_q.pop_front());
    if (link_valid_o === 1'b1) check({17'h0, link_sample_o}, {17'h0, smp_q.pop_front()});
  end
  task finish_test;
    begin
      // a noted result that never showed up is a miss as well
      if (rd_q.size() != 0 || smp_q.size() != 0) failures = failures + 1;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #20000;
    failures = failures + 1;
    finish_test;
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rnd = lfsr(rnd);
    fuse = rnd[7:0];
    fuse_dither_i <= fuse;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    fuse_dither_i <= ~fuse;
    wb(0, `IDX_DITHER_CONTROL, 4'h1, 32'h0, {25'h0, fuse});
    wb(0, `IDX_STAMP_CONTROL, 4'h1, 32'h0, {25'h0, `RST_STAMP_CONTROL});
    wb(0, `IDX_LINK_ENABLE, 4'h1, 32'h0, {25'h0, `RST_LINK_ENABLE});
    check({31'h0, serializer_clock_gate_o, link_reset_o}, 33'h0);
    wb(1, `IDX_LINK_ENABLE, 4'h1, 32'h0, 33'h0);
    // software keeps reserved bits zero; a write without sel_i[0] stores nothing
    for (i = 0; i < 12; i = i + 1) begin
      rnd = lfsr(rnd);
      ix = (i % 3 == 0) ? `IDX_DITHER_CONTROL : (i % 3 == 1) ? `IDX_STAMP_CONTROL : `IDX_LINK_ENABLE;
      m = (i % 3 == 0) ? 8'h07 : 8'h01;
      wb(1, ix, 4'h1, {24'h0, rnd[7:0] & m}, 33'h0);
      wb(1, ix, 4'hE, {24'h0, ~rnd[7:0] & m}, 33'h0);
      wb(0, ix, 4'h1, 32'h0, {25'h0, rnd[7:0] & m});
      if (i % 3 == 2) wb(1, `IDX_LINK_ENABLE, 4'h1, 32'h0, 33'h0);
    end
    wb(1, 10'h001, 4'h1, 32'h5, {1'b1, 32'h0});
    wb(0, 10'h001, 4'h1, 32'h0, {1'b1, 32'h0});
    wb(1, `IDX_LINK_ENABLE, 4'h1, 32'h0, 33'h0);
    check({31'h0, serializer_clock_gate_o, link_reset_o}, 33'h3);
    wb(1, `IDX_STAMP_CONTROL, 4'h1, 32'h1, 33'h0);
    wb(1, `IDX_LINK_ENABLE, 4'h1, 32'h1, 33'h0);
    check({31'h0, serializer_clock_gate_o, link_reset_o}, 33'h0);
    stream(1'b1);
    wb(0, `IDX_LINK_STATUS, 4'h1, 32'h0, {25'h0, 8'h05});
    wb(1, `IDX_LINK_ENABLE, 4'h1, 32'h0, 33'h0);
    wb(1, `IDX_STAMP_CONTROL, 4'h1, 32'h0, 33'h0);
    wb(1, `IDX_LINK_ENABLE, 4'h1, 32'h1, 33'h0);
    stream(1'b0);
    finish_test;
  end
endmodule // dither_and_stamp_control_bench

// ---- dither_and_stamp_control_properties.sv ----
// port-level checks for the dither and stamp control bank
`timescale 1ns/10ps
`include "dither_stamp_regs.vh"
module dither_and_stamp_control_properties (
  input wire                   clk_i,
  input wire                   rst_i,
  input wire                   cyc_i,
  input wire                   stb_i,
  input wire                   we_i,
  input wire [11:0]            adr_i,
  input wire [3:0]             sel_i,
  input wire [31:0]            dat_i,
  input wire [31:0]            dat_o,
  input wire                   ack_o,
  input wire                   err_o,
  input wire [`CONV_WIDTH-1:0] conv_sample_i,
  input wire                   conv_valid_i,
  input wire [`LINK_WIDTH-1:0] link_sample_o,
  input wire                   link_valid_o,
  input wire                   dither_on_o,
  input wire                   dither_size_select_o,
  input wire                   rounding_error_target_o,
  input wire                   link_reset_o,
  input wire                   serializer_power_down_o,
  input wire [7:0]             lane_align_cs_o
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  wire [9:0] idx = adr_i[11:2];
  wire hit = cyc_i & stb_i & ~ack_o & ~err_o;
  wire wr0 = we_i & sel_i[0];
  wire mapped = (idx == `IDX_DITHER_CONTROL) | (idx == `IDX_STAMP_CONTROL) |
                (idx == `IDX_LINK_ENABLE) | (idx == `IDX_LINK_STATUS);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************************************
  // assertions
  // ****************************************************************
  answer_once_a: assert property (hit |=> (ack_o ^ err_o) ##1 !(ack_o | err_o))
    else $error("bus answer not a single pulse");
  unmapped_err_a: assert property (hit && !mapped |=> err_o)
    else $error("unmapped access not refused");
  dither_write_a: assert property (ack_o && $past(wr0 && idx == `IDX_DITHER_CONTROL) |->
    {rounding_error_target_o, dither_size_select_o, dither_on_o} == $past(dat_i[2:0]))
    else $error("dither controls differ from written bits");
  link_off_a: assert property (ack_o && $past(wr0 && idx == `IDX_LINK_ENABLE) |->
    link_reset_o == !$past(dat_i[0])) else $error("link reset not following enable bit");
  link_gate_a: assert property (serializer_power_down_o == link_reset_o)
    else $error("serializer power down differs from link reset");
  cs_zero_a: assert property (lane_align_cs_o == 8'h00)
    else $error("control bits count not zero");
  upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  sample_lat_a: assert property (link_valid_o == $past(conv_valid_i, 5))
    else $error("sample valid latency wrong");
  sample_pos_a: assert property (link_valid_o |->
    link_sample_o[`LINK_WIDTH-1:`LINK_WIDTH-`CONV_WIDTH] == $past(conv_sample_i, 5))
    else $error("converter sample misplaced in link field");
endmodule // dither_and_stamp_control_properties

bind dither_and_stamp_control dither_and_stamp_control_properties props_u (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .conv_sample_i, .conv_valid_i, .link_sample_o,
  .link_valid_o, .dither_on_o, .dither_size_select_o, .rounding_error_target_o, .link_reset_o,
  .serializer_power_down_o, .lane_align_cs_o);

// ---- dither_stamp_regs.vh ----
// register offsets, fields, reset values and timing for the dither and stamp control bank
`ifndef DITHER_STAMP_REGS_VH
`define DITHER_STAMP_REGS_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_DITHER_CONTROL     10'h09D
`define IDX_STAMP_CONTROL      10'h160
`define IDX_LINK_ENABLE        10'h200
`define IDX_LINK_STATUS        10'h3F0

// ****************************************************************
// field positions
// ****************************************************************
`define FLD_DITHER_ON          0
`define FLD_DITHER_SIZE        1
`define FLD_ROUND_TARGET       2
`define FLD_STAMP_INSERTION    0
`define FLD_SERIAL_LINK_ON     0

// ****************************************************************
// reset values
// ****************************************************************
`define RST_STAMP_CONTROL      8'h00
`define RST_LINK_ENABLE        8'h01

// ****************************************************************
// sample layout and latency
// ****************************************************************
`define CONV_WIDTH             12
`define LINK_WIDTH             16
`define CONV_LATENCY           4

`endif

// ---- stamp_delay_line.v ----
// delay line that carries the timestamp with the same latency as the samples
`timescale 1ns/10ps
`include "dither_stamp_regs.vh"
module stamp_delay_line (
  input  wire                     clk_i,
  input  wire                     rst_i,
  input  wire                     stamp_i,
  input  wire [`CONV_WIDTH-1:0]   sample_i,
  input  wire                     valid_i,
  output wire                     stamp_o,
  output wire [`CONV_WIDTH-1:0]   sample_o,
  output wire                     valid_o
);
  reg  [`CONV_LATENCY-1:0]        stamp_q;
  reg  [`CONV_LATENCY-1:0]        valid_q;
  reg  [`CONV_WIDTH-1:0]          data_q [0:`CONV_LATENCY-1];
  integer                         k;

  // ****************************************************************
  // matched shift stages
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      stamp_q <= {`CONV_LATENCY{1'b0}};
      valid_q <= {`CONV_LATENCY{1'b0}};
      for (k = 0; k < `CONV_LATENCY; k = k + 1) begin
        data_q[k] <= {`CONV_WIDTH{1'b0}};
      end
    end else begin
      stamp_q <= {stamp_q[`CONV_LATENCY-2:0], stamp_i};
      valid_q <= {valid_q[`CONV_LATENCY-2:0], valid_i};
      data_q[0] <= sample_i;
      for (k = 1; k < `CONV_LATENCY; k = k + 1) begin
        data_q[k] <= data_q[k-1];
      end
    end
  end

  assign stamp_o  = stamp_q[`CONV_LATENCY-1];
  assign valid_o  = valid_q[`CONV_LATENCY-1];
  assign sample_o = data_q[`CONV_LATENCY-1];
endmodule // stamp_delay_line
